// file: pkg/arig_pkg.sv
// Package: register map, field layout and carrier types for the routing block
package arig_pkg;

   // ----------------------------------------------------------------
   // Register offsets (printed offsets are indices; byte addr = 4*idx)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_RESERVED  = 8'h00;
   localparam logic [7:0] IDX_CAP2_SEL  = 8'h01;
   localparam logic [7:0] IDX_CAP3_SEL  = 8'h02;
   localparam logic [7:0] IDX_G1_LVL    = 8'h03;
   localparam logic [7:0] IDX_G2_LVL    = 8'h04;
   localparam logic [7:0] IDX_G3_LVL    = 8'h05;
   localparam logic [7:0] IDX_G1_CMS    = 8'h06;
   localparam logic [7:0] IDX_G2_CMS    = 8'h07;
   localparam logic [7:0] IDX_G3_CMS    = 8'h08;
   localparam logic [7:0] IDX_G1_SW     = 8'h09;
   localparam logic [7:0] IDX_ROUTE_CTL = 8'h20;
   localparam logic [7:0] IDX_G4_LVL    = 8'h25;
   localparam logic [7:0] IDX_G4_CMS    = 8'h26;
   localparam logic [7:0] IDX_G4_SW     = 8'h27;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] G4_CHAN_MASK  = 8'hC3;
   localparam logic [7:0] CAP_SRC_MASK  = 8'h1F;
   localparam int         ACQ_HW_BIT    = 2;
   localparam int         GCFG_LO_BIT   = 6;
   localparam int         GCFG_HI_BIT   = 7;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_SW_G1     = 8'h00;

   // Pin owner selection per group-4 channel
   typedef enum logic [1:0] {
      ARIG_OWN_PORT,
      ARIG_OWN_LOW,
      ARIG_OWN_GROUP,
      ARIG_OWN_TIMER
   } arig_owner_t;

   // Per-channel drive bundle toward the pad logic
   typedef struct packed {
      logic [3:0] switch_closed;
      logic [3:0] port_blocked;
      logic [3:0] force_low;
      logic [3:0] from_group;
      logic [3:0] from_timer;
   } arig_pad_ctl_t;

endpackage

// file: hdl/arig_sync2.sv
// Two-flop synchroniser for a bus of pin levels
module arig_sync2 #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

// file: hdl/arig_ctrl.sv
// APB register file and group-4 pin routing control
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module arig_ctrl (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pin levels, groups 1 to 4 (asynchronous)
   input  wire logic [7:0]  grp1_pin_level,
   input  wire logic [7:0]  grp2_pin_level,
   input  wire logic [7:0]  grp3_pin_level,
   input  wire logic [7:0]  grp4_pin_level,
   // Group config bits 7:6 of the group register, outside this block
   input  wire logic [1:0]  group_config_bits,
   // Pad control, group 4 channels in order bits 7,6,1,0
   output arig_pkg::arig_pad_ctl_t pad_ctl,
   // Group 1 switch and control selects for the other pad logic
   output logic      [7:0]  grp1_switch,
   output logic      [7:0]  grp1_protect,
   output logic      [7:0]  grp2_protect,
   output logic      [7:0]  grp3_protect,
   output logic      [4:0]  capture2_source_field,
   output logic      [4:0]  capture3_source_field
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] cap2_r;
   logic [7:0] cap3_r;
   logic [7:0] g1_cms_r;
   logic [7:0] g2_cms_r;
   logic [7:0] g3_cms_r;
   logic [7:0] g1_sw_r;
   logic [7:0] g4_cms_r;
   logic [7:0] g4_sw_r;
   logic [7:0] route_ctl_r;
   logic [7:0] lvl1_s;
   logic [7:0] lvl2_s;
   logic [7:0] lvl3_s;
   logic [7:0] lvl4_s;
   logic [7:0] rd_nxt;
   logic       hit_nxt;
   logic       wr_en;
   logic       access;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic       wr_ok;
   logic       ro_idx;
   arig_pkg::arig_pad_ctl_t pad_nxt;

   assign access = psel && penable;
   assign wr_en  = access && pwrite && pstrb[0];
   assign idx    = paddr[9:2];
   assign wbyte  = pwdata[7:0];
   assign wr_ok  = wr_en && paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
   assign ro_idx = (idx == arig_pkg::IDX_G1_LVL) ||
                   (idx == arig_pkg::IDX_G2_LVL) ||
                   (idx == arig_pkg::IDX_G3_LVL) ||
                   (idx == arig_pkg::IDX_G4_LVL);

   // ----------------------------------------------------------------
   // Pin level synchronisers
   // ----------------------------------------------------------------
   arig_sync2 #(.WIDTH(32)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({grp4_pin_level, grp3_pin_level,
                  grp2_pin_level, grp1_pin_level}),
      .sync_out ({lvl4_s, lvl3_s, lvl2_s, lvl1_s})
   );

   // ----------------------------------------------------------------
   // Register writes, one process per register
   // ----------------------------------------------------------------
   // Capture selects keep five bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap2_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_CAP2_SEL) begin
         cap2_r <= wbyte & arig_pkg::CAP_SRC_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap3_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_CAP3_SEL) begin
         cap3_r <= wbyte & arig_pkg::CAP_SRC_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g1_cms_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_G1_CMS) begin
         g1_cms_r <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g2_cms_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_G2_CMS) begin
         g2_cms_r <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g3_cms_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_G3_CMS) begin
         g3_cms_r <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g1_sw_r <= arig_pkg::RST_SW_G1;
      end else if (wr_ok && idx == arig_pkg::IDX_G1_SW) begin
         g1_sw_r <= wbyte;
      end
   end

   // Reserved bits 5:2 of the group-4 registers stay zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g4_cms_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_G4_CMS) begin
         g4_cms_r <= wbyte & arig_pkg::G4_CHAN_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g4_sw_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_G4_SW) begin
         g4_sw_r <= wbyte & arig_pkg::G4_CHAN_MASK;
      end
   end

   // Only the acquisition-mode bit is kept; the rest reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_ctl_r <= arig_pkg::RST_ZERO;
      end else if (wr_ok && idx == arig_pkg::IDX_ROUTE_CTL) begin
         route_ctl_r <= {5'h00, wbyte[arig_pkg::ACQ_HW_BIT], 2'h0};
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   always_comb begin
      rd_nxt  = 8'h00;
      hit_nxt = 1'b1;
      if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
         hit_nxt = 1'b0;
      end else begin
         case (idx)
            arig_pkg::IDX_RESERVED:  rd_nxt = 8'h00;
            arig_pkg::IDX_CAP2_SEL:  rd_nxt = cap2_r;
            arig_pkg::IDX_CAP3_SEL:  rd_nxt = cap3_r;
            arig_pkg::IDX_G1_LVL:    rd_nxt = lvl1_s;
            arig_pkg::IDX_G2_LVL:    rd_nxt = lvl2_s;
            arig_pkg::IDX_G3_LVL:    rd_nxt = lvl3_s;
            arig_pkg::IDX_G1_CMS:    rd_nxt = g1_cms_r;
            arig_pkg::IDX_G2_CMS:    rd_nxt = g2_cms_r;
            arig_pkg::IDX_G3_CMS:    rd_nxt = g3_cms_r;
            arig_pkg::IDX_G1_SW:     rd_nxt = g1_sw_r;
            arig_pkg::IDX_ROUTE_CTL: rd_nxt = route_ctl_r;
            arig_pkg::IDX_G4_LVL:    begin
               rd_nxt = lvl4_s & arig_pkg::G4_CHAN_MASK;
            end
            arig_pkg::IDX_G4_CMS:    rd_nxt = g4_cms_r;
            arig_pkg::IDX_G4_SW:     rd_nxt = g4_sw_r;
            default:                 hit_nxt = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB answer: no wait state, data registered in the setup cycle
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_nxt};
      end
   end

   // Ready is a one-cycle pulse in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // Writes to read-only levels are also flagged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= !hit_nxt || (pwrite && ro_idx);
      end else begin
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Group-4 pin ownership
   // ----------------------------------------------------------------
   function automatic arig_pkg::arig_owner_t owner_of(
      input logic prot, input logic sw, input logic hw);
      if (!prot) begin
         owner_of = arig_pkg::ARIG_OWN_PORT;
      end else if (!sw) begin
         owner_of = arig_pkg::ARIG_OWN_LOW;
      end else if (hw) begin
         owner_of = arig_pkg::ARIG_OWN_TIMER;
      end else begin
         owner_of = arig_pkg::ARIG_OWN_GROUP;
      end
   endfunction

   always_comb begin
      logic [3:0] prot;
      logic [3:0] sw;
      logic       hw;
      arig_pkg::arig_owner_t own;
      prot    = {g4_cms_r[7:6], g4_cms_r[1:0]};
      sw      = {g4_sw_r[7:6], g4_sw_r[1:0]};
      hw      = route_ctl_r[arig_pkg::ACQ_HW_BIT];
      own     = arig_pkg::ARIG_OWN_PORT;
      pad_nxt = '0;
      for (int i = 0; i < 4; i++) begin
         own = owner_of(prot[i], sw[i], hw);
         pad_nxt.port_blocked[i]  = prot[i];
         // Switch closed only in normal mode; ADC may still close it
         pad_nxt.switch_closed[i] = !prot[i] && sw[i];
         pad_nxt.force_low[i]     = own == arig_pkg::ARIG_OWN_LOW;
         pad_nxt.from_group[i]    = own == arig_pkg::ARIG_OWN_GROUP;
         pad_nxt.from_timer[i]    = own == arig_pkg::ARIG_OWN_TIMER;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_ctl <= '0;
      end else begin
         pad_ctl <= pad_nxt;
      end
   end

   // Plain copies for the pad logic of groups 1 to 3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp1_switch           <= 8'h00;
         grp1_protect          <= 8'h00;
         grp2_protect          <= 8'h00;
         grp3_protect          <= 8'h00;
         capture2_source_field <= 5'h00;
         capture3_source_field <= 5'h00;
      end else begin
         grp1_switch           <= g1_sw_r;
         grp1_protect          <= g1_cms_r;
         grp2_protect          <= g2_cms_r;
         grp3_protect          <= g3_cms_r;
         capture2_source_field <= cap2_r[4:0];
         capture3_source_field <= cap3_r[4:0];
      end
   end

   // Group config bits are consumed by the pad logic with from_group
   logic unused_gcfg;
   assign unused_gcfg = ^group_config_bits;

endmodule

// file: testbench/arig_monitor.sv
// Checker: bus answer and pad ownership of the routing block
module arig_monitor (
   // Clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // Register bus
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // Pads
   input wire arig_pkg::arig_pad_ctl_t pad_ctl
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_done; psel && penable && pready; endsequence
   a_ready_next: assert property (s_setup |=> s_done)
      else $error("no answer after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("answer longer than one cycle");
   a_level_ro: assert property (s_done ##0 (pwrite &&
      paddr inside {12'h00C, 12'h010, 12'h014, 12'h094}) |-> pslverr)
      else $error("level write not refused");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_grp4_rsvd: assert property (s_done ##0 (!pwrite &&
      paddr[9:2] inside {8'h25, 8'h26, 8'h27}) |-> prdata[5:2] == 4'h0)
      else $error("reserved bits read set");
   a_prot_open: assert property (
      (pad_ctl.switch_closed & pad_ctl.port_blocked) == 4'h0)
      else $error("switch closed in protected mode");
   a_owner_one: assert property (pad_ctl.port_blocked ==
      (pad_ctl.force_low | pad_ctl.from_group | pad_ctl.from_timer))
      else $error("protected pad without owner");
   a_owner_excl: assert property (
      ((pad_ctl.force_low & pad_ctl.from_group)
      | (pad_ctl.force_low & pad_ctl.from_timer)
      | (pad_ctl.from_group & pad_ctl.from_timer)) == 4'h0)
      else $error("pad with two owners");
   a_pad_cause: assert property (!$stable(pad_ctl) |->
      $past(pready && pwrite, 2))
      else $error("pad change without write");
endmodule

bind arig_ctrl arig_monitor u_arig_monitor (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .pad_ctl);

// file: testbench/arig_pin_model.sv
// Pin-side model: pad levels and group configuration bits
module arig_pin_model (
   // Clock
   input wire logic        pclk,
   // Requested levels, group 4 in the top byte
   input wire logic [31:0] want,
   // Pins
   output logic      [7:0] grp1_pin_level,
   output logic      [7:0] grp2_pin_level,
   output logic      [7:0] grp3_pin_level,
   output logic      [7:0] grp4_pin_level,
   output logic      [1:0] group_config_bits
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins move on the falling edge, away from the sampling edge
   always @(negedge pclk) begin
      {grp4_pin_level, grp3_pin_level, grp2_pin_level, grp1_pin_level} <= want;
      group_config_bits <= want[31:30];
   end
endmodule

// file: testbench/tb_top.sv
// Testbench: register map, pin levels and pad routing modes
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic                    pwrite = 0, pready, pslverr, er;
   logic [11:0]             paddr = 12'h000;
   logic [31:0]             pwdata = 32'h0, prdata, rd, want = 32'h0;
   logic [3:0]              pstrb = 4'h0;
   logic [7:0]              g1, g2, g3, g4, sw1, p1, p2, p3;
   logic [4:0]              c2, c3;
   logic [1:0]              gcb;
   arig_pkg::arig_pad_ctl_t pad;
   int                      fails = 0, check_count = 0;

   always #5 pclk = ~pclk;

   arig_pin_model u_arig_pin_model (.pclk(pclk), .want(want),
      .grp1_pin_level(g1), .grp2_pin_level(g2), .grp3_pin_level(g3),
      .grp4_pin_level(g4), .group_config_bits(gcb));
   arig_ctrl u_arig_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .grp1_pin_level(g1), .grp2_pin_level(g2), .grp3_pin_level(g3),
      .grp4_pin_level(g4), .group_config_bits(gcb), .pad_ctl(pad),
      .grp1_switch(sw1), .grp1_protect(p1), .grp2_protect(p2),
      .grp3_protect(p3), .capture2_source_field(c2),
      .capture3_source_field(c3));

   // ----------------------------------------------------------------
   // Bus and closing
   // ----------------------------------------------------------------
   task automatic end_of_test;
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Byte address is four times the register index
   task automatic apb(input logic w, input logic [7:0] ix,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= {2'b00, ix, 2'b00};
      pwdata <= d; pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin fails++; end_of_test(); end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_map;
      logic [7:0] ix[9] = '{8'h01, 8'h02, 8'h06, 8'h07, 8'h08, 8'h09,
                            8'h20, 8'h26, 8'h27};
      logic [7:0] mk[9] = '{8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                            8'h04, 8'hC3, 8'hC3};
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, ix[i], 32'h0);
         `CHK(rd, 32'h0)
         apb(1'b1, ix[i], 32'hFFFF_FFFF);
         apb(1'b0, ix[i], 32'h0);
         `CHK(rd, {24'h0, mk[i]})
      end
      `CHK({c2, c3, sw1, p1, p2, p3}, {10'h3FF, 32'hFFFF_FFFF})
      for (int i = 0; i < 9; i++) apb(1'b1, ix[i], 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      `CHK({er, rd}, 33'h0)
      apb(1'b0, 8'h0A, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
   endtask

   task automatic t_levels;
      want <= 32'hFF3C_5AA5;
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'h03, 32'h0);
      `CHK(rd, 32'hA5)
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd, 32'h5A)
      apb(1'b0, 8'h05, 32'h0);
      `CHK(rd, 32'h3C)
      apb(1'b0, 8'h25, 32'h0);
      `CHK(rd, 32'hC3)
      apb(1'b1, 8'h25, 32'h0);
      `CHK(er, 1'b1)
      want <= 32'h8100_0000;
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'h25, 32'h0);
      `CHK(rd, 32'h81)
   endtask

   // Channels at bits 1,0 protected; switch bits 7 and 1 set, reserved 0
   task automatic t_modes;
      apb(1'b1, 8'h26, 32'h03);
      apb(1'b1, 8'h27, 32'h82);
      for (int am = 0; am < 2; am++) begin
         apb(1'b1, 8'h20, am << 2);
         repeat (2) @(posedge pclk);
         `CHK(pad.switch_closed, 4'b1000)
         `CHK(pad.port_blocked, 4'b0011)
         `CHK(pad.force_low, 4'b0001)
         `CHK(pad.from_group, (am == 0) ? 4'b0010 : 4'b0000)
         `CHK(pad.from_timer, (am == 1) ? 4'b0010 : 4'b0000)
      end
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_map();
      t_levels();
      t_modes();
      end_of_test();
   end
endmodule
